/* hw/preset_regs_defines.svh */
`ifndef PRESET_REGS_DEFINES_SVH
`define PRESET_REGS_DEFINES_SVH

`define FREQ_B1_ADDR 12'h248
`define PHASE_B1_ADDR 12'h24c
`define FREQ_B2_ADDR 12'h250
`define PHASE_B2_ADDR 12'h254
`define FREQ_B3_ADDR 12'h258
`define PHASE_B3_ADDR 12'h25c
`define STARTUP_STATE_ADDR 12'h270
`define SILICON_REV_ADDR 12'h297
`define FREQ_RESET 32'hc0000000
`define PHASE_RESET 16'h0000
`define INIT_DONE_BIT 0
`define REV_CODE_MSB 4
`define REV_RSVD_ZERO 3'h0
// Arbitrary revision code; it does not name any real part variant.
`define SILICON_REV_CODE 5'h1b
`define INIT_CYCLES 8'h20
`define NUM_PRESETS 3

`endif

/* hw/preset_regs_pkg.sv */
package preset_regs_pkg;
  typedef enum logic [1:0] {
    init_busy = 2'b00,
    init_done = 2'b01
  } init_state_type;
endpackage : preset_regs_pkg

/* hw/init_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "preset_regs_defines.svh"

module init_sequencer (
  input wire logic clk_sys,
  input wire logic srst,
  output logic done_q
);
  preset_regs_pkg::init_state_type state_q;
  logic [7:0] count_q;

  // A fixed settling count stands in for the power-up initialization engine.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= preset_regs_pkg::init_busy;
      count_q <= 8'h00;
      done_q <= 1'b0;
    end else begin
      case (state_q)
        preset_regs_pkg::init_busy: begin
          if (count_q == `INIT_CYCLES - 8'h01) begin
            state_q <= preset_regs_pkg::init_done;
            done_q <= 1'b1;
          end else begin
            count_q <= count_q + 8'h01;
          end
        end
        default: begin
          done_q <= 1'b1;
        end
      endcase
    end
  end
endmodule : init_sequencer
`default_nettype wire

/* hw/preset_regs.sv */
// Notes on behaviour
// - Channel B presets 1-3 each have a 32-bit RW tuning word, reset c0000000.
// - Channel B presets 1-3 each have a 16-bit RW phase word, reset zero.
// - Startup status bit 0 reads 1 only after initialization has finished.
// - Startup status bits 7:1 are reserved read-only; host masks them.
// - Revision register holds a 5-bit code in 4:0; bits 7:5 reset zero.
// - In interleaved mode channel B preset words are ignored downstream.
`timescale 1ns/1ps
`default_nettype none
`include "preset_regs_defines.svh"

module preset_regs (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic interleave_mode,
  input wire logic [1:0] preset_sel,
  output logic [31:0] reg_rdata_q,
  output logic reg_rvalid_q,
  output logic init_done_q,
  output logic [31:0] chan_b_tuning_word_q,
  output logic [15:0] chan_b_phase_word_q,
  output logic chan_b_words_valid_q
);
  logic [31:0] freq_q [`NUM_PRESETS];
  logic [15:0] phase_q [`NUM_PRESETS];
  logic [7:0] rev_q;
  logic done_w;

  function automatic logic [1:0] preset_of(input logic [11:0] a);
    if (a == `FREQ_B1_ADDR || a == `PHASE_B1_ADDR) begin
      preset_of = 2'h0;
    end else if (a == `FREQ_B2_ADDR || a == `PHASE_B2_ADDR) begin
      preset_of = 2'h1;
    end else begin
      preset_of = 2'h2;
    end
  endfunction : preset_of

  function automatic logic is_freq(input logic [11:0] a);
    is_freq = (a == `FREQ_B1_ADDR) || (a == `FREQ_B2_ADDR) ||
      (a == `FREQ_B3_ADDR);
  endfunction : is_freq

  function automatic logic is_phase(input logic [11:0] a);
    is_phase = (a == `PHASE_B1_ADDR) || (a == `PHASE_B2_ADDR) ||
      (a == `PHASE_B3_ADDR);
  endfunction : is_phase

  init_sequencer u_init (
    .clk_sys(clk_sys),
    .srst(srst),
    .done_q(done_w)
  );

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      init_done_q <= 1'b0;
    end else begin
      init_done_q <= done_w;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_PRESETS; gi++) begin : g_preset
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          freq_q[gi] <= `FREQ_RESET;
          phase_q[gi] <= `PHASE_RESET;
        end else if (reg_wr && preset_of(reg_addr) == 2'(gi)) begin
          if (is_freq(reg_addr)) begin
            freq_q[gi] <= reg_wdata;
          end
          if (is_phase(reg_addr)) begin
            phase_q[gi] <= reg_wdata[15:0];
          end
        end
      end
    end
  endgenerate

  // The revision field is writable, but software is expected to leave it.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rev_q <= {`REV_RSVD_ZERO, `SILICON_REV_CODE};
    end else if (reg_wr && reg_addr == `SILICON_REV_ADDR) begin
      rev_q <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata_q <= 32'h00000000;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      if (!reg_rd) begin
        reg_rdata_q <= 32'h00000000;
      end else if (is_freq(reg_addr)) begin
        reg_rdata_q <= freq_q[preset_of(reg_addr)];
      end else if (is_phase(reg_addr)) begin
        reg_rdata_q <= {16'h0000, phase_q[preset_of(reg_addr)]};
      end else if (reg_addr == `STARTUP_STATE_ADDR) begin
        // Reserved bits are returned as zero; hosts must still mask them.
        reg_rdata_q <= {31'h00000000, init_done_q};
      end else if (reg_addr == `SILICON_REV_ADDR) begin
        reg_rdata_q <= {24'h000000, rev_q};
      end else begin
        reg_rdata_q <= 32'h00000000;
      end
    end
  end

  // Interleaved mode marks the channel B words unused; the words still
  // follow the selection so that leaving the mode needs no reload.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      chan_b_tuning_word_q <= `FREQ_RESET;
      chan_b_phase_word_q <= `PHASE_RESET;
      chan_b_words_valid_q <= 1'b0;
    end else begin
      chan_b_words_valid_q <= !interleave_mode;
      if (preset_sel < 2'h3) begin
        chan_b_tuning_word_q <= freq_q[preset_sel];
        chan_b_phase_word_q <= phase_q[preset_sel];
      end
    end
  end

  rst_defaults_a: assert property (@(posedge clk_sys)
    srst |=> freq_q[0] == `FREQ_RESET && phase_q[2] == `PHASE_RESET)
    else $error("preset reset value wrong");
  freq_write_a: assert property (@(posedge clk_sys) disable iff (srst)
    reg_wr && reg_addr == `FREQ_B2_ADDR |=> freq_q[1] == $past(reg_wdata))
    else $error("tuning word write lost");
  phase_write_a: assert property (@(posedge clk_sys) disable iff (srst)
    reg_wr && reg_addr == `PHASE_B3_ADDR |=>
    phase_q[2] == $past(reg_wdata[15:0]))
    else $error("phase word write lost");
  init_low_a: assert property (@(posedge clk_sys)
    srst |=> !init_done_q [*8])
    else $error("init done too early");
  init_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
    init_done_q |=> init_done_q)
    else $error("init done dropped");
  status_rsvd_a: assert property (@(posedge clk_sys) disable iff (srst)
    reg_rd && reg_addr == `STARTUP_STATE_ADDR |=>
    reg_rdata_q[31:1] == 31'h00000000)
    else $error("status reserved bits nonzero");
  rev_rsvd_a: assert property (@(posedge clk_sys)
    srst |=> rev_q[7:5] == 3'h0)
    else $error("revision reserved bits nonzero");
  interleave_gate_a: assert property (@(posedge clk_sys)
    disable iff (srst)
    interleave_mode |=> !chan_b_words_valid_q)
    else $error("channel B words used in interleave");
  readback_a: assert property (@(posedge clk_sys) disable iff (srst)
    reg_rd && reg_addr == `FREQ_B1_ADDR |=> reg_rvalid_q &&
    reg_rdata_q == $past(freq_q[0]))
    else $error("readback mismatch");

  init_seen_c: cover property (@(posedge clk_sys) $rose(init_done_q));
  write_read_c: cover property (@(posedge clk_sys)
    reg_wr && reg_addr == `PHASE_B1_ADDR ##1 reg_rd);
  interleave_c: cover property (@(posedge clk_sys) interleave_mode);
endmodule : preset_regs
`default_nettype wire

/* test/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk_sys,
  input wire logic init_done_q,
  output logic reg_wr,
  output logic reg_rd,
  output logic [11:0] reg_addr,
  output logic [31:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 32'h0;
  end
  task automatic access(input logic wr, input logic [11:0] a,
                        input logic [31:0] d);
    wait (init_done_q === 1'b1);
    @(posedge clk_sys);
    reg_wr <= wr;
    reg_rd <= ~wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    // Stale bus values would hide a design that samples late.
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : access
endmodule : host_model
`default_nettype wire

/* test/preset_regs_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "preset_regs_defines.svh"
module preset_regs_test;
  logic clk_sys, srst, reg_wr, reg_rd, interleave_mode, init_done_q;
  logic reg_rvalid_q, chan_b_words_valid_q;
  logic [1:0] preset_sel;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata_q, chan_b_tuning_word_q, wv[6];
  logic [15:0] chan_b_phase_word_q;
  logic [11:0] at[6] = '{`FREQ_B1_ADDR, `PHASE_B1_ADDR, `FREQ_B2_ADDR,
                         `PHASE_B2_ADDR, `FREQ_B3_ADDR, `PHASE_B3_ADDR};
  logic [31:0] exp_q[$], mask_q[$];
  int fail_count, checked, seed = 32'h96b7;
  preset_regs u_preset_regs (.clk_sys(clk_sys), .srst(srst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .interleave_mode(interleave_mode),
    .preset_sel(preset_sel), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .init_done_q(init_done_q),
    .chan_b_tuning_word_q(chan_b_tuning_word_q),
    .chan_b_phase_word_q(chan_b_phase_word_q),
    .chan_b_words_valid_q(chan_b_words_valid_q));
  host_model u_host_model (.clk_sys(clk_sys), .init_done_q(init_done_q),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata));
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    exp_q.push_back(e & m);
    mask_q.push_back(m);
    u_host_model.access(1'b0, a, 32'h0);
  endtask : rd
  task automatic close_out;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  always @(posedge clk_sys) if (reg_rvalid_q === 1'b1) begin
    if (exp_q.size() == 0) chk("spurious read", 32'h1, 32'h0);
    else chk("read data", exp_q.pop_front(),
             reg_rdata_q & mask_q.pop_front());
  end
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    #125000;
    fail_count++;
    close_out();
  end
  initial begin
    srst = 1'b1;
    interleave_mode = 1'b0;
    preset_sel = 2'h0;
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    #1 chk("init flag", 32'h0, {31'h0, init_done_q});
    for (int i = 0; i < 6; i++) begin
      rd(at[i], i[0] ? `PHASE_RESET : `FREQ_RESET,
         i[0] ? 32'hffff : '1);
      wv[i] = $random(seed);
      u_host_model.access(1'b1, at[i], wv[i]);
      rd(at[i], wv[i], i[0] ? 32'hffff : '1);
    end
    u_host_model.access(1'b1, `STARTUP_STATE_ADDR, 32'h0);
    rd(`STARTUP_STATE_ADDR, 32'h1, 32'h1);
    rd(`SILICON_REV_ADDR, {27'h0, `SILICON_REV_CODE}, 32'hff);
    u_host_model.access(1'b1, 12'h2a0, wv[0]);
    rd(12'h2a0, 32'h0, '1);
    for (int i = 0; i < 3; i++) begin
      preset_sel <= i[1:0];
      repeat (3) @(posedge clk_sys);
      chk("tuning word", wv[2*i], chan_b_tuning_word_q);
      chk("phase word", {16'h0, wv[2*i+1][15:0]},
          {16'h0, chan_b_phase_word_q});
      chk("words valid", 32'h1, {31'h0, chan_b_words_valid_q});
    end
    interleave_mode <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("words valid", 32'h0, {31'h0, chan_b_words_valid_q});
    repeat (4) @(posedge clk_sys);
    chk("reads left", 32'h0, 32'(exp_q.size()));
    close_out();
  end
endmodule : preset_regs_test
`default_nettype wire
